// file: rtl/rtc_ctl_defines.vh
// Offsets, field positions, reset values and timing counts of the clock control block.
// Assumes a 50 MHz system clock and a register of up to 32 bits at one Wishbone word each.
`ifndef RTC_CTL_DEFINES_VH
`define RTC_CTL_DEFINES_VH

// Register byte addresses
`define ADDR_RTC_CONTROL    8'h04
`define ADDR_TIMER_LOW      8'h08
`define ADDR_CAPTURE_HOLD   8'h0C
`define ADDR_IRQ_STATUS     8'h10
`define ADDR_IRQ_MASK       8'h14

// Control field positions
`define BIT_OSC_ENABLE      7
`define BIT_MCD_ENABLE      6
`define BIT_OSC_FAIL        5
`define BIT_TIMER_RUN       4
`define BIT_RESERVED        3
`define BIT_FAST_MODE       2
`define BIT_SET_START       1
`define BIT_CAPTURE_START   0

// Interrupt status layout
`define IRQ_OSC_FAIL        0
`define IRQ_SET_DONE        1
`define IRQ_CAPTURE_DONE    2

// Reset values
`define CONTROL_RESET       8'h00
`define MASK_RESET          3'h0

// Missing clock timeout: 100 us of 50 MHz system clock
`define MCD_TIMEOUT_CYCLES  16'h1388

// Oscillator ticks a slow set or capture waits for
`define TRANSFER_TICKS      2'h2

`endif

// file: rtl/rtc_control_register.v
// Control register, 32-bit timer, capture holding register and missing clock
// detector of the low power clock. Assumes a classic Wishbone master on CLK and
// a slow oscillator output RTC_OSC_IN that is already synchronous to CLK.
//
// Function
// - Bit 7 turns oscillator and bias on
// - Bit 6 enables missing clock detector
// - Timeout sets sticky fail flag, software clears
// - Bit 4 runs timer while bit 7 is set, else holds value
// - Bit 1 starts set, self-clears when done
// - Bit 0 starts capture, self-clears when done
// - Set loads holding value into running timer
// - Capture snapshots timer into holding register
// - Detector times out after 100 us stuck
// - Slow transfers need running timer, two ticks
`timescale 1ns/100ps
`default_nettype none
`include "rtc_ctl_defines.vh"

module rtc_control_register #(
    parameter [15:0] MCD_TIMEOUT = `MCD_TIMEOUT_CYCLES
) (
    // Clock and reset
    input  wire        CLK,
    input  wire        RESET_N,
    // Wishbone slave
    input  wire        CYC_I,
    input  wire        STB_I,
    input  wire        WE_I,
    input  wire [7:0]  ADR_I,
    input  wire [3:0]  SEL_I,
    input  wire [31:0] DAT_I,
    output reg  [31:0] DAT_O,
    output reg         ACK_O,
    // Oscillator side
    input  wire        RTC_OSC_IN,
    output reg         OSC_ENABLE,
    output reg         MCD_ENABLE,
    // Interrupt
    output reg         IRQ
);

    // Control fields
    reg        rtc_oscillator_enable;
    reg        missing_clock_detect_enable;
    reg        oscillator_fail_flag;
    reg        timer_run;
    reg        fast_transfer_mode;
    reg        timer_set_start;
    reg        timer_capture_start;
    // Timer, holding register and transfer progress
    reg [31:0] timer;
    reg [31:0] capture_holding_regs;
    reg [1:0]  set_ticks;
    reg [1:0]  cap_ticks;
    // Detector and interrupt state
    reg [15:0] stuck_count;
    reg        osc_last;
    reg        tick;
    reg [2:0]  irq_status;
    reg [2:0]  irq_mask;
    // Read mux output
    reg [31:0] next_dat;

    // Decode and event wires
    wire       req;
    wire       wr_byte0;
    wire       ctl_write;
    wire       mask_write;
    wire       hold_write;
    wire       stat_read;
    wire       osc_edge;
    wire       timeout;
    wire       set_done;
    wire       cap_done;
    wire [2:0] irq_event;
    wire [7:0] control_value;

    genvar g;

    // Exact byte address match; every write and status-read decode goes through here, the read mux decodes ADR_I on its own
    function addr_hit;
        input [7:0] addr;
        input [7:0] target;
        begin
            addr_hit = (addr == target);
        end
    endfunction

    // Shared by set and capture so both finish under the same terms
    function transfer_done;
        input       start;
        input       fast;
        input       run;
        input [1:0] ticks;
        begin
            transfer_done = start & (fast | (run & (ticks == `TRANSFER_TICKS)));
        end
    endfunction

    function [7:0] lane_merge;
        input [7:0] old_byte;
        input [7:0] new_byte;
        input       sel;
        begin
            lane_merge = sel ? new_byte : old_byte;
        end
    endfunction

    // Bus decode; a request counts once, on the edge before its ack
    assign req        = CYC_I & STB_I & ~ACK_O;
    assign wr_byte0   = req & WE_I & SEL_I[0];
    assign ctl_write  = wr_byte0 & addr_hit(ADR_I, `ADDR_RTC_CONTROL);
    assign mask_write = wr_byte0 & addr_hit(ADR_I, `ADDR_IRQ_MASK);
    assign hold_write = req & WE_I & addr_hit(ADR_I, `ADDR_CAPTURE_HOLD);
    assign stat_read  = req & ~WE_I & addr_hit(ADR_I, `ADDR_IRQ_STATUS);

    // Detector and transfer completion
    assign osc_edge   = RTC_OSC_IN ^ osc_last;
    assign timeout    = missing_clock_detect_enable & (stuck_count == MCD_TIMEOUT);
    // Fast mode moves data on the system clock; slow mode waits for ticks
    assign set_done   = transfer_done(timer_set_start, fast_transfer_mode,
                                      timer_run, set_ticks);
    assign cap_done   = transfer_done(timer_capture_start, fast_transfer_mode,
                                      timer_run, cap_ticks);
    assign irq_event  = {cap_done, set_done, timeout};

    // Control image as software reads it; bit 3 is tied low
    assign control_value = {rtc_oscillator_enable, missing_clock_detect_enable,
                            oscillator_fail_flag, timer_run, 1'b0,
                            fast_transfer_mode, timer_set_start,
                            timer_capture_start};

    // Oscillator edge; tick marks a rising edge one clock late
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            osc_last <= 1'b0;
            tick     <= 1'b0;
        end else begin
            osc_last <= RTC_OSC_IN;
            tick     <= osc_edge & RTC_OSC_IN;
        end
    end

    // Stuck-level counter; saturates so the fail event repeats while stuck
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            stuck_count <= 16'h0000;
        end else if (!missing_clock_detect_enable || osc_edge) begin
            stuck_count <= 16'h0000;
        end else if (stuck_count != MCD_TIMEOUT) begin
            stuck_count <= stuck_count + 16'h0001;
        end
    end

    // Control register
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            rtc_oscillator_enable       <= 1'b0;
            missing_clock_detect_enable <= 1'b0;
            oscillator_fail_flag        <= 1'b0;
            timer_run                   <= 1'b0;
            fast_transfer_mode          <= 1'b0;
            timer_set_start             <= 1'b0;
            timer_capture_start         <= 1'b0;
        end else begin
            if (ctl_write) begin
                rtc_oscillator_enable       <= DAT_I[`BIT_OSC_ENABLE];
                missing_clock_detect_enable <= DAT_I[`BIT_MCD_ENABLE];
                timer_run                   <= DAT_I[`BIT_TIMER_RUN];
                fast_transfer_mode          <= DAT_I[`BIT_FAST_MODE];
            end
            // Timeout wins over a software clear in the same cycle
            if (timeout) begin
                oscillator_fail_flag <= 1'b1;
            end else if (ctl_write && !DAT_I[`BIT_OSC_FAIL]) begin
                oscillator_fail_flag <= 1'b0;
            end
            // Writing 0 cannot cancel a transfer in flight
            if (set_done) begin
                timer_set_start <= 1'b0;
            end else if (ctl_write && DAT_I[`BIT_SET_START]) begin
                timer_set_start <= 1'b1;
            end
            if (cap_done) begin
                timer_capture_start <= 1'b0;
            end else if (ctl_write && DAT_I[`BIT_CAPTURE_START]) begin
                timer_capture_start <= 1'b1;
            end
        end
    end

    // Slow-mode tick counters; ticks count only while the timer runs
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            set_ticks <= 2'h0;
        end else if (!timer_set_start || set_done) begin
            set_ticks <= 2'h0;
        end else if (tick && timer_run && set_ticks != `TRANSFER_TICKS) begin
            set_ticks <= set_ticks + 2'h1;
        end
    end

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            cap_ticks <= 2'h0;
        end else if (!timer_capture_start || cap_done) begin
            cap_ticks <= 2'h0;
        end else if (tick && timer_run && cap_ticks != `TRANSFER_TICKS) begin
            cap_ticks <= cap_ticks + 2'h1;
        end
    end

    // Timer and holding register; set wins over counting
    generate
        for (g = 0; g < 4; g = g + 1) begin : hold_lane
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    capture_holding_regs[8*g+7:8*g] <= 8'h00;
                end else if (cap_done) begin
                    capture_holding_regs[8*g+7:8*g] <= timer[8*g+7:8*g];
                end else if (hold_write) begin
                    capture_holding_regs[8*g+7:8*g] <= lane_merge(
                        capture_holding_regs[8*g+7:8*g], DAT_I[8*g+7:8*g], SEL_I[g]);
                end
            end
        end
    endgenerate

    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            timer <= 32'h0000_0000;
        end else if (set_done) begin
            timer <= capture_holding_regs;
        end else if (timer_run && rtc_oscillator_enable && tick) begin
            timer <= timer + 32'h0000_0001;
        end
    end

    // Status bits; a new event wins over the clear-on-read
    generate
        for (g = 0; g < 3; g = g + 1) begin : status_bit
            always @(posedge CLK or negedge RESET_N) begin
                if (!RESET_N) begin
                    irq_status[g] <= 1'b0;
                end else if (irq_event[g]) begin
                    irq_status[g] <= 1'b1;
                end else if (stat_read) begin
                    irq_status[g] <= 1'b0;
                end
            end
        end
    endgenerate

    // Mask and level output; the output lags status by one clock
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            irq_mask <= `MASK_RESET;
            IRQ      <= 1'b0;
        end else begin
            if (mask_write) begin
                irq_mask <= DAT_I[2:0];
            end
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // Read mux
    always @* begin
        next_dat = 32'h0000_0000;
        case (ADR_I)
            `ADDR_RTC_CONTROL:  next_dat[7:0] = control_value;
            `ADDR_TIMER_LOW:    next_dat = timer;
            `ADDR_CAPTURE_HOLD: next_dat = capture_holding_regs;
            `ADDR_IRQ_STATUS:   next_dat[2:0] = irq_status;
            `ADDR_IRQ_MASK:     next_dat[2:0] = irq_mask;
            default:            next_dat = 32'h0000_0000;
        endcase
    end

    // Bus answer one cycle after request; unmapped reads give zero
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            ACK_O <= 1'b0;
            DAT_O <= 32'h0000_0000;
        end else begin
            ACK_O <= req;
            DAT_O <= req ? next_dat : 32'h0000_0000;
        end
    end

    // Enable pins copy the register a clock later, straight from flops
    always @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            OSC_ENABLE <= 1'b0;
            MCD_ENABLE <= 1'b0;
        end else begin
            OSC_ENABLE <= rtc_oscillator_enable;
            MCD_ENABLE <= missing_clock_detect_enable;
        end
    end

endmodule // rtc_control_register

`default_nettype wire

// file: bench/rtc_ctl_chk.sv
// Bus and enable-output checks for the clock control register.
// Sees only top ports; bound to every instance below.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_ctl_defines.vh"
module rtc_ctl_chk (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET_N,
    // Bus
    input wire logic        CYC_I,
    input wire logic        STB_I,
    input wire logic        WE_I,
    input wire logic [7:0]  ADR_I,
    input wire logic [3:0]  SEL_I,
    input wire logic [31:0] DAT_I,
    input wire logic [31:0] DAT_O,
    input wire logic        ACK_O,
    // Oscillator side
    input wire logic        OSC_ENABLE,
    input wire logic        MCD_ENABLE
);
    logic osc_want;
    logic mcd_want;
    wire  ctl_wr = CYC_I & STB_I & ~ACK_O & WE_I & SEL_I[0] & (ADR_I == `ADDR_RTC_CONTROL);
    wire  rd_ack = ACK_O & ~WE_I;
    // Enables may lag the register by one edge, so two edges are skipped
    always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) begin
            osc_want <= 1'b0;
            mcd_want <= 1'b0;
        end else if (ctl_wr) begin
            osc_want <= DAT_I[7];
            mcd_want <= DAT_I[6];
        end
    end
    default clocking @(posedge CLK);
    endclocking
    default disable iff (!RESET_N);
    sequence req_taken;
        CYC_I && STB_I && !ACK_O;
    endsequence
    sequence settled;
        !$past(ctl_wr) && !$past(ctl_wr, 2);
    endsequence
    a_ack_next: assert property (req_taken |=> ACK_O) else $error("missing ack");
    a_ack_pulse: assert property (ACK_O |=> !ACK_O) else $error("ack too long");
    a_ack_cause: assert property ($rose(ACK_O) |-> $past(CYC_I && STB_I)) else $error("stray ack");
    a_dat_idle: assert property (!ACK_O |-> DAT_O == 32'h0000_0000) else $error("data idle");
    a_osc_follows: assert property (settled |-> OSC_ENABLE == osc_want) else $error("osc");
    a_mcd_follows: assert property (settled |-> MCD_ENABLE == mcd_want) else $error("mcd");
    a_rsv_zero: assert property (rd_ack && ADR_I == `ADDR_RTC_CONTROL |->
        DAT_O[3] == 1'b0 && DAT_O[31:8] == 24'h00_0000) else $error("reserved bit");
    a_unmapped_zero: assert property (rd_ack && !(ADR_I inside {`ADDR_RTC_CONTROL,
        `ADDR_TIMER_LOW, `ADDR_CAPTURE_HOLD, `ADDR_IRQ_STATUS, `ADDR_IRQ_MASK})
        |-> DAT_O == 32'h0000_0000) else $error("unmapped read");
endmodule // rtc_ctl_chk
bind rtc_control_register rtc_ctl_chk u_chk (.CLK, .RESET_N, .CYC_I, .STB_I, .WE_I, .ADR_I,
    .SEL_I, .DAT_I, .DAT_O, .ACK_O, .OSC_ENABLE, .MCD_ENABLE);
`default_nettype wire

// file: bench/rtc_control_register_tb.sv
// Self-checking bench for the clock control register.
// Bench plays bus master and oscillator; short detector timeout.
`timescale 1ns/100ps
`default_nettype none
`include "rtc_ctl_defines.vh"
module rtc_control_register_tb;
    logic        CLK = 0, RESET_N = 0, req = 0, we = 0, osc = 0, osc_run = 1;
    logic        ack, osc_en, mcd_en, irq;
    logic [1:0]  oc = 0;
    logic [3:0]  sel = 0;
    logic [7:0]  adr = 0;
    logic [31:0] dat = 0, rdat, q, t1;
    int          miscompares = 0, samples_checked = 0, cycles = 0;
    always #10 CLK = ~CLK;
    // Oscillator at an eighth of CLK, well under the 4x limit
    always @(posedge CLK) begin
        oc <= oc + 2'h1;
        if (oc == 2'h3 && osc_run) osc <= ~osc;
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            miscompares++;
            stop_test;
        end
    end
    rtc_control_register #(.MCD_TIMEOUT(16'h0014)) dut (.CLK(CLK), .RESET_N(RESET_N),
        .CYC_I(req), .STB_I(req), .WE_I(we), .ADR_I(adr), .SEL_I(sel), .DAT_I(dat),
        .DAT_O(rdat), .ACK_O(ack), .RTC_OSC_IN(osc), .OSC_ENABLE(osc_en),
        .MCD_ENABLE(mcd_en), .IRQ(irq));
    task automatic stop_test;
        if (miscompares == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s);
        @(posedge CLK);
        {req, we, adr, dat, sel} <= {1'b1, w, a, d, s};
        // Only the bench-wide cycle ceiling ends a wait for ack
        do @(posedge CLK); while (ack !== 1'b1);
        q = rdat;
        req <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        wb(1'b0, a, 32'h0000_0000, 4'hF);
        check(q, exp);
    endtask
    task automatic t_reset;
        rd(`ADDR_RTC_CONTROL, 32'h0000_0000);
        rd(`ADDR_IRQ_MASK, 32'h0000_0000);
        wb(1'b1, 8'h20, 32'h0000_00FF, 4'hF);
        rd(8'h20, 32'h0000_0000);
    endtask
    task automatic t_control;
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00FF, 4'hF);
        repeat (3) @(posedge CLK);
        check({30'h0, osc_en, mcd_en}, 32'h0000_0003);
        rd(`ADDR_RTC_CONTROL, 32'h0000_00D4);
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_0000, 4'hE);
        rd(`ADDR_RTC_CONTROL, 32'h0000_00D4);
        rd(`ADDR_IRQ_STATUS, 32'h0000_0006);
        rd(`ADDR_IRQ_STATUS, 32'h0000_0000);
    endtask
    task automatic t_transfer;
        wb(1'b1, `ADDR_CAPTURE_HOLD, 32'h1234_5678, 4'hF);
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00D6, 4'hF);
        repeat (40) @(posedge CLK);
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00C4, 4'hF);
        wb(1'b0, `ADDR_TIMER_LOW, 32'h0000_0000, 4'hF);
        t1 = q;
        check({31'h0, (t1 - 32'h1234_567B) < 32'h0000_0006}, 32'h0000_0001);
        repeat (40) @(posedge CLK);
        rd(`ADDR_TIMER_LOW, t1);
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00C5, 4'hF);
        rd(`ADDR_CAPTURE_HOLD, t1);
    endtask
    task automatic t_slow;
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00C2, 4'hF);
        repeat (40) @(posedge CLK);
        rd(`ADDR_RTC_CONTROL, 32'h0000_00C2);
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00D0, 4'hF);
        repeat (30) @(posedge CLK);
        rd(`ADDR_RTC_CONTROL, 32'h0000_00D0);
    endtask
    task automatic t_fail;
        wb(1'b0, `ADDR_IRQ_STATUS, 32'h0000_0000, 4'hF);
        osc_run <= 1'b0;
        repeat (40) @(posedge CLK);
        check({31'h0, irq}, 32'h0000_0000);
        wb(1'b1, `ADDR_IRQ_MASK, 32'h0000_0001, 4'hF);
        repeat (3) @(posedge CLK);
        check({31'h0, irq}, 32'h0000_0001);
        osc_run <= 1'b1;
        repeat (10) @(posedge CLK);
        rd(`ADDR_IRQ_STATUS, 32'h0000_0001);
        repeat (3) @(posedge CLK);
        check({31'h0, irq}, 32'h0000_0000);
        rd(`ADDR_RTC_CONTROL, 32'h0000_00F0);
        wb(1'b1, `ADDR_RTC_CONTROL, 32'h0000_00D0, 4'hF);
        rd(`ADDR_RTC_CONTROL, 32'h0000_00D0);
    endtask
    initial begin
        repeat (6) @(posedge CLK);
        RESET_N <= 1'b1;
        t_reset;
        t_control;
        t_transfer;
        t_slow;
        t_fail;
        stop_test;
    end
endmodule // rtc_control_register_tb
`default_nettype wire
